/* File: core/cie_core.sv */
// Instruction decode and execute core of the 8-bit controller
`timescale 1ns/1ps
module cie_core
  import cie_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  // Program space
  output logic [11:0]      progAddr,
  input  wire logic [7:0]  progData,
  // Option
  input  wire logic        watchdogSel,
  // Status
  output logic [7:0]       accOut,
  output logic             zeroFlag,
  output logic             carryFlag,
  output logic             haltReq,
  output logic             waitReq,
  output logic             instDone
);

  function automatic cie_cls_t decodeOp(input logic [7:0] op);
    cie_cls_t c;
    unique case (op[3:0])
      NIB_CALL: c = CLS_CALL;
      NIB_JUMP: c = CLS_JUMP;
      NIB_BTST: c = CLS_BTST;
      NIB_BSET: c = CLS_BSET;
      NIB_SDIR: c = CLS_SDIR;
      NIB_IND:  c = CLS_IND;
      NIB_DIR:  c = CLS_DIR;
      NIB_IMM:  c = op[POS_POLAR] ? CLS_INH : CLS_IMM;
      default:  c = CLS_SBR;
    endcase
    return c;
  endfunction : decodeOp

  cie_dmem_if dmem ();

  cie_data_ram u_ram (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .mem      (dmem.mem)
  );

  cie_state_t  state_r,    state_nxt;
  logic [2:0]  cyc_r,      cyc_nxt;
  logic [7:0]  op_r,       op_nxt;
  logic [7:0]  b1_r,       b1_nxt;
  logic [7:0]  b2_r,       b2_nxt;
  logic [11:0] pc_r,       pc_nxt;
  logic [11:0] instAddr_r, instAddr_nxt;
  logic [7:0]  addr_r,     addr_nxt;
  logic [7:0]  acc_r,      acc_nxt;
  logic        zero_r,     zero_nxt;
  logic        carry_r,    carry_nxt;
  logic        shZero_r,   shZero_nxt;
  logic        shCarry_r,  shCarry_nxt;
  logic        haltReq_r,  haltReq_nxt;
  logic        waitReq_r,  waitReq_nxt;
  logic [7:0]  wreg_r     [WREG_COUNT];
  logic [7:0]  wreg_nxt   [WREG_COUNT];
  logic [11:0] stack_r    [STACK_DEPTH];
  logic [11:0] stack_nxt  [STACK_DEPTH];

  cie_cls_t    cls;
  logic [2:0]  lastCyc;
  logic [1:0]  instLen;
  logic        commit;
  logic [7:0]  effAddr;
  logic        isWreg;
  logic [7:0]  operand;
  logic [7:0]  opnd;
  logic [8:0]  sum9;
  logic [8:0]  diff9;
  logic [2:0]  bitSel;
  logic        testBit;
  logic        memWr;
  logic [7:0]  wrVal;
  logic        brTake;
  logic [11:0] extTarget;

  assign cls       = decodeOp(op_r);
  assign commit    = (state_r == ST_WORK) && (cyc_r == lastCyc);
  assign bitSel    = {op_r[5], op_r[6], op_r[7]};
  assign isWreg    = (addr_r[7:2] == WREG_BASE[7:2]);
  assign operand   = isWreg ? wreg_r[addr_r[1:0]] : dmem.rdData;
  assign opnd      = (cls == CLS_IMM) ? b1_r : operand;
  assign sum9      = {1'b0, acc_r} + {1'b0, opnd};
  assign diff9     = {1'b0, acc_r} - {1'b0, opnd};
  assign testBit   = operand[bitSel];
  assign extTarget = {op_r[7:4], b1_r};

  // Length and cycle count per class
  always_comb
  begin
    instLen = LEN_TWO;
    lastCyc = CYC_STD - 3'd1;
    unique case (cls)
      CLS_SBR:  begin instLen = LEN_ONE;   lastCyc = CYC_SHORT - 3'd1; end
      CLS_BTST: begin instLen = LEN_THREE; lastCyc = CYC_BTST - 3'd1;  end
      CLS_SDIR, CLS_IND: instLen = LEN_ONE;
      CLS_INH:
      begin
        instLen = LEN_ONE;
        if (op_r[7:5] < INH_CPL)
          lastCyc = CYC_SHORT - 3'd1;
      end
      default:  instLen = LEN_TWO;
    endcase
  end

  // Operand address: pointer, short-direct register, or address byte
  always_comb
  begin
    unique case (cls)
      CLS_IND:  effAddr = wreg_r[{1'b0, op_r[POS_PTR_SEL]}];
      CLS_SDIR: effAddr = WREG_BASE + {6'h00, op_r[7:6]};
      default:  effAddr = b1_r;
    endcase
  end

  // Short branch condition
  always_comb
  begin
    unique case (op_r[2:1])
      BR_NZ: brTake = !zero_r;
      BR_NC: brTake = !carry_r;
      BR_Z:  brTake = zero_r;
      BR_C:  brTake = carry_r;
    endcase
  end

  assign dmem.addr   = (state_r == ST_WORK && cyc_r == CYC_READ) ? effAddr : addr_r;
  assign dmem.rdEn   = (state_r == ST_WORK) && (cyc_r == CYC_READ);
  assign dmem.wrEn   = commit && memWr;
  assign dmem.wrData = wrVal;

  // Sequencer and execution
  always_comb
  begin
    state_nxt = state_r;   cyc_nxt = cyc_r;     op_nxt = op_r;
    b1_nxt = b1_r;         b2_nxt = b2_r;       pc_nxt = pc_r;
    instAddr_nxt = instAddr_r;                  addr_nxt = addr_r;
    acc_nxt = acc_r;       zero_nxt = zero_r;   carry_nxt = carry_r;
    shZero_nxt = shZero_r; shCarry_nxt = shCarry_r;
    haltReq_nxt = 1'b0;    waitReq_nxt = 1'b0;
    wreg_nxt = wreg_r;     stack_nxt = stack_r;
    memWr = 1'b0;          wrVal = acc_r;
    if (state_r == ST_FETCH)
    begin
      op_nxt       = progData;
      instAddr_nxt = pc_r;
      pc_nxt       = pc_r + 12'd1;
      cyc_nxt      = 3'd1;
      state_nxt    = ST_WORK;
    end
    else
    begin
      if (cyc_r < {1'b0, instLen})
      begin
        pc_nxt = pc_r + 12'd1;
        if (cyc_r == 3'd1)
          b1_nxt = progData;
        else
          b2_nxt = progData;
      end
      if (cyc_r == CYC_READ)
        addr_nxt = effAddr;
      cyc_nxt = cyc_r + 3'd1;
      if (commit)
      begin
        state_nxt = ST_FETCH;
        cyc_nxt   = 3'd0;
        unique case (cls)
          CLS_SBR:
            if (brTake)
            begin
              if (op_r[POS_BR_DIR])
                pc_nxt = instAddr_r - {8'h00, op_r[7:4]};
              else
                pc_nxt = instAddr_r + 12'd1 + {8'h00, op_r[7:4]};
            end
          CLS_CALL:
          begin
            for (int i = 1; i < STACK_DEPTH; i++)
              stack_nxt[i] = stack_r[i-1];
            stack_nxt[0] = pc_r;
            shZero_nxt   = zero_r;
            shCarry_nxt  = carry_r;
            pc_nxt       = extTarget;
          end
          CLS_JUMP: pc_nxt = extTarget;
          CLS_BTST:
          begin
            carry_nxt = testBit;
            if (testBit == op_r[POS_POLAR])
              pc_nxt = instAddr_r + 12'd2 + {{4{b2_r[7]}}, b2_r};
          end
          CLS_BSET:
          begin
            memWr = 1'b1;
            wrVal = operand;
            wrVal[bitSel] = op_r[POS_POLAR];
          end
          CLS_SDIR:
            unique case (op_r[5:4])
              SD_INC: begin memWr = 1'b1; wrVal = operand + 8'd1; zero_nxt = (wrVal == 8'h00); end
              SD_DEC: begin memWr = 1'b1; wrVal = operand - 8'd1; zero_nxt = (wrVal == 8'h00); end
              SD_LDA: begin acc_nxt = operand; zero_nxt = (operand == 8'h00); end
              SD_LDR: begin memWr = 1'b1; wrVal = acc_r; zero_nxt = (acc_r == 8'h00); end
            endcase
          CLS_INH:
            unique case (op_r[7:5])
              INH_NOP: ;
              INH_RET, INH_IRET:
              begin
                pc_nxt = stack_r[0];
                for (int i = 0; i < STACK_DEPTH - 1; i++)
                  stack_nxt[i] = stack_r[i+1];
                if (op_r[7:5] == INH_IRET)
                begin
                  zero_nxt  = shZero_r;
                  carry_nxt = shCarry_r;
                end
              end
              INH_STOP:
                if (watchdogSel)
                  waitReq_nxt = 1'b1;
                else
                  haltReq_nxt = 1'b1;
              INH_WAIT: waitReq_nxt = 1'b1;
              INH_CPL:  begin acc_nxt = ~acc_r; zero_nxt = (acc_r == 8'hff); carry_nxt = acc_r[7]; end
              INH_ROL:  begin {carry_nxt, acc_nxt} = {acc_r, carry_r}; zero_nxt = ({acc_r[6:0], carry_r} == 8'h00); end
              INH_SHL:  begin {carry_nxt, acc_nxt} = {acc_r, 1'b0}; zero_nxt = (acc_r[6:0] == 7'h00); end
            endcase
          default:
            unique case (op_r[7:5])
              ALU_LD:  begin acc_nxt = opnd; zero_nxt = (opnd == 8'h00); end
              ALU_CP:  begin zero_nxt = (diff9[7:0] == 8'h00); carry_nxt = diff9[8]; end
              ALU_ADD: begin acc_nxt = sum9[7:0]; zero_nxt = (sum9[7:0] == 8'h00); carry_nxt = sum9[8]; end
              ALU_SUB: begin acc_nxt = diff9[7:0]; zero_nxt = (diff9[7:0] == 8'h00); carry_nxt = diff9[8]; end
              ALU_AND: begin acc_nxt = acc_r & opnd; zero_nxt = ((acc_r & opnd) == 8'h00); carry_nxt = 1'b0; end
              ALU_INC:
                if (cls == CLS_IMM)
                begin
                  memWr = 1'b1;
                  wrVal = 8'h00;
                end
                else
                begin
                  memWr = 1'b1; wrVal = operand + 8'd1; zero_nxt = (wrVal == 8'h00);
                end
              ALU_DEC:
                if (cls == CLS_IMM)
                begin
                  acc_nxt = 8'h00; zero_nxt = 1'b1; carry_nxt = 1'b0;
                end
                else
                begin
                  memWr = 1'b1; wrVal = operand - 8'd1; zero_nxt = (wrVal == 8'h00);
                end
              ALU_ST:
                if (cls != CLS_IMM)
                begin
                  memWr = 1'b1; wrVal = acc_r; zero_nxt = (acc_r == 8'h00);
                end
            endcase
        endcase
        if (memWr && isWreg)
          wreg_nxt[addr_r[1:0]] = wrVal;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_r <= ST_FETCH;    cyc_r <= 3'd0;       op_r <= ACC_RESET;
      b1_r <= ACC_RESET;      b2_r <= ACC_RESET;   pc_r <= PC_RESET;
      instAddr_r <= PC_RESET; addr_r <= ACC_RESET; acc_r <= ACC_RESET;
      zero_r <= 1'b0;         carry_r <= 1'b0;     shZero_r <= 1'b0;
      shCarry_r <= 1'b0;      haltReq_r <= 1'b0;   waitReq_r <= 1'b0;
      for (int i = 0; i < WREG_COUNT; i++)
        wreg_r[i] <= WREG_RESET;
      for (int i = 0; i < STACK_DEPTH; i++)
        stack_r[i] <= PC_RESET;
    end
    else
    begin
      state_r <= state_nxt;       cyc_r <= cyc_nxt;       op_r <= op_nxt;
      b1_r <= b1_nxt;             b2_r <= b2_nxt;         pc_r <= pc_nxt;
      instAddr_r <= instAddr_nxt; addr_r <= addr_nxt;     acc_r <= acc_nxt;
      zero_r <= zero_nxt;         carry_r <= carry_nxt;   shZero_r <= shZero_nxt;
      shCarry_r <= shCarry_nxt;   haltReq_r <= haltReq_nxt; waitReq_r <= waitReq_nxt;
      wreg_r <= wreg_nxt;         stack_r <= stack_nxt;
    end
  end

  assign progAddr  = pc_r;
  assign accOut    = acc_r;
  assign zeroFlag  = zero_r;
  assign carryFlag = carry_r;
  assign haltReq   = haltReq_r;
  assign waitReq   = waitReq_r;
  assign instDone  = commit;

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  logic     inFetch;
  cie_cls_t fetchCls;
  assign inFetch  = (state_r == ST_FETCH) && arst_n;  // Release edge fetches nothing
  assign fetchCls = decodeOp(progData);

  sequence fetchOf(cie_cls_t k);
    inFetch && (fetchCls == k);
  endsequence
  sequence doneAfter4;
    !commit [*2] ##1 commit;
  endsequence

  short_br_time_a: assert property (fetchOf(CLS_SBR) |=> commit) else $error("short branch not two cycles");
  bit_test_time_a: assert property (fetchOf(CLS_BTST) |=> !commit [*3] ##1 commit)
    else $error("bit test branch not five cycles");
  bit_op_time_a: assert property (fetchOf(CLS_BSET) |=> doneAfter4) else $error("bit op not four cycles");
  jump_time_a: assert property (fetchOf(CLS_JUMP) or fetchOf(CLS_CALL) |=> doneAfter4)
    else $error("jump or call not four cycles");
  alu_time_a: assert property (fetchOf(CLS_IND) or fetchOf(CLS_DIR) or fetchOf(CLS_IMM) |=> doneAfter4)
    else $error("alu op not four cycles");
  bit_carry_a: assert property (commit && cls == CLS_BTST |=> carryFlag == $past(testBit))
    else $error("tested bit not in carry");
  bit_flags_a: assert property (commit && cls == CLS_BSET |=> $stable(zeroFlag) && $stable(carryFlag))
    else $error("bit op changed flags");
  long_target_a: assert property (commit && cls == CLS_JUMP |=> progAddr == $past(extTarget) && $stable(carryFlag))
    else $error("jump target wrong");
  stop_as_wait_a: assert property (commit && cls == CLS_INH && op_r[7:5] == INH_STOP && watchdogSel
    |=> waitReq && !haltReq) else $error("stop not turned into wait");
  com_acc_a: assert property (commit && cls == CLS_INH && op_r[7:5] == INH_CPL |=> accOut == ~$past(acc_r))
    else $error("complement wrong");
  inc_carry_a: assert property (commit && cls == CLS_SDIR && !op_r[4] |=> $stable(carryFlag))
    else $error("inc or dec changed carry");
  wreg_map_a: assert property (commit && memWr && addr_r == WREG_BASE |=> wreg_r[0] == $past(wrVal))
    else $error("write to 80h missed X");

endmodule : cie_core

/* File: core/cie_data_ram.sv */
// 256-byte data space memory with registered read data
`timescale 1ns/1ps
module cie_data_ram
  import cie_pkg::*;
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic arst_n,
  // Memory port
  cie_dmem_if.mem   mem
);

  logic [7:0] store [256];
  logic [7:0] rdData_r;
  logic [7:0] rdData_nxt;

  always_comb
  begin
    rdData_nxt = mem.rdEn ? store[mem.addr] : rdData_r;
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      rdData_r <= ACC_RESET;
    else
      rdData_r <= rdData_nxt;
  end

  always_ff @(posedge core_clk)
  begin
    if (mem.wrEn)
      store[mem.addr] <= mem.wrData;
  end

  assign mem.rdData = rdData_r;

endmodule : cie_data_ram

/* File: core/cie_dmem_if.sv */
// Data space port between the core and its data memory
`timescale 1ns/1ps
interface cie_dmem_if;
  logic [7:0] addr;
  logic       rdEn;
  logic       wrEn;
  logic [7:0] wrData;
  logic [7:0] rdData;

  modport core (output addr, output rdEn, output wrEn, output wrData, input rdData);
  modport mem  (input addr, input rdEn, input wrEn, input wrData, output rdData);
endinterface : cie_dmem_if

/* File: core/cie_pkg.sv */
// Shared constants and types of the instruction execute core
package cie_pkg;

  // Reset values
  localparam logic [11:0] PC_RESET   = 12'h000;
  localparam logic [7:0]  ACC_RESET  = 8'h00;
  localparam logic [7:0]  WREG_RESET = 8'h00;

  // Short-direct working registers X, Y, V, W at 80h..83h
  localparam logic [7:0]  WREG_BASE   = 8'h80;
  localparam int          WREG_COUNT  = 4;
  localparam int          STACK_DEPTH = 6;

  // Opcode low nibble per addressing class (odd nibbles; even low bit means short branch)
  localparam logic [3:0]  NIB_CALL = 4'h1;
  localparam logic [3:0]  NIB_BTST = 4'h3;
  localparam logic [3:0]  NIB_SDIR = 4'h5;
  localparam logic [3:0]  NIB_IND  = 4'h7;
  localparam logic [3:0]  NIB_JUMP = 4'h9;
  localparam logic [3:0]  NIB_BSET = 4'hb;
  localparam logic [3:0]  NIB_IMM  = 4'hd;
  localparam logic [3:0]  NIB_DIR  = 4'hf;

  // Field positions
  localparam int          POS_PTR_SEL = 4;
  localparam int          POS_POLAR   = 4;
  localparam int          POS_BR_DIR  = 3;

  // Short branch tests, opcode bits 2:1
  localparam logic [1:0]  BR_NZ = 2'h0;
  localparam logic [1:0]  BR_NC = 2'h1;
  localparam logic [1:0]  BR_Z  = 2'h2;
  localparam logic [1:0]  BR_C  = 2'h3;

  // Operation field, opcode bits 7:5, for indirect, direct and immediate classes
  localparam logic [2:0]  ALU_LD  = 3'h0;
  localparam logic [2:0]  ALU_CP  = 3'h1;
  localparam logic [2:0]  ALU_ADD = 3'h2;
  localparam logic [2:0]  ALU_INC = 3'h3;
  localparam logic [2:0]  ALU_ST  = 3'h4;
  localparam logic [2:0]  ALU_AND = 3'h5;
  localparam logic [2:0]  ALU_SUB = 3'h6;
  localparam logic [2:0]  ALU_DEC = 3'h7;

  // Short-direct sub-operation, opcode bits 5:4; register in bits 7:6
  localparam logic [1:0]  SD_INC = 2'h0;
  localparam logic [1:0]  SD_LDA = 2'h1;
  localparam logic [1:0]  SD_DEC = 2'h2;
  localparam logic [1:0]  SD_LDR = 2'h3;

  // Inherent operations, opcode bits 7:5 with bit 4 set
  localparam logic [2:0]  INH_NOP  = 3'h0;
  localparam logic [2:0]  INH_RET  = 3'h1;
  localparam logic [2:0]  INH_IRET = 3'h2;
  localparam logic [2:0]  INH_STOP = 3'h3;
  localparam logic [2:0]  INH_WAIT = 3'h4;
  localparam logic [2:0]  INH_CPL  = 3'h5;
  localparam logic [2:0]  INH_ROL  = 3'h6;
  localparam logic [2:0]  INH_SHL  = 3'h7;

  // Cycle counts and lengths
  localparam logic [2:0]  CYC_SHORT = 3'd2;
  localparam logic [2:0]  CYC_STD   = 3'd4;
  localparam logic [2:0]  CYC_BTST  = 3'd5;
  localparam logic [2:0]  CYC_READ  = 3'd2;
  localparam logic [1:0]  LEN_ONE   = 2'd1;
  localparam logic [1:0]  LEN_TWO   = 2'd2;
  localparam logic [1:0]  LEN_THREE = 2'd3;

  typedef enum logic [3:0] {
    CLS_SBR, CLS_CALL, CLS_JUMP, CLS_BTST, CLS_BSET, CLS_SDIR, CLS_IND, CLS_DIR, CLS_IMM, CLS_INH
  } cie_cls_t;

  typedef enum logic {
    ST_FETCH, ST_WORK
  } cie_state_t;

endpackage : cie_pkg

/* File: test/cie_core_tb.sv */
// Self-checking bench for the instruction execute core, with an instruction-level model
`timescale 1ns/1ps
module cie_core_tb;
  import cie_pkg::*;
  logic        core_clk;
  logic        arst_n;
  logic [11:0] progAddr;
  logic [7:0]  progData;
  logic        watchdogSel;
  logic [7:0]  accOut;
  logic        zeroFlag;
  logic        carryFlag;
  logic        haltReq;
  logic        waitReq;
  logic        instDone;
  logic [7:0]  rom [4096];
  int          fail_count;
  int          checks_done;
  integer      seed;
  int          wp;
  int          mPc, mAcc, mZ, mC, svZ, svC, mWd, endAddr;
  int          mMem [256];
  int          mStk [$];

  cie_core i_cie_core (
    .core_clk    (core_clk),
    .arst_n      (arst_n),
    .progAddr    (progAddr),
    .progData    (progData),
    .watchdogSel (watchdogSel),
    .accOut      (accOut),
    .zeroFlag    (zeroFlag),
    .carryFlag   (carryFlag),
    .haltReq     (haltReq),
    .waitReq     (waitReq),
    .instDone    (instDone)
  );

  // Program space answers combinationally, as an asynchronous ROM
  assign progData = rom[progAddr];

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  function automatic logic [7:0] rnd();
    return 8'($random(seed));
  endfunction : rnd

  task automatic emit(input logic [7:0] b);
    rom[wp] = b;
    wp = (wp + 1) % 4096;
  endtask : emit

  task automatic jmp(input logic [3:0] nib, input int tgt);
    logic [11:0] t;
    t = 12'(tgt);
    emit({t[11:8], nib});
    emit(t[7:0]);
  endtask : jmp

  task automatic build();
    logic [7:0] a1, a2;
    logic [2:0] b;
    int         p;
    for (int i = 0; i < 4096; i++) rom[i] = 8'h1d;
    wp = 0;
    a1 = 8'h40 + (rnd() & 8'h1f);
    a2 = 8'h60 + (rnd() & 8'h1f);
    b = 3'(rnd());
    emit(8'h0d); emit(rnd()); emit(8'h8f); emit(a1); emit(8'h0d); emit(rnd()); emit(8'h4f); emit(a1);
    emit(8'h4d); emit(rnd()); emit(8'hcd); emit(rnd()); emit(8'h2d); emit(rnd()); emit(8'had); emit(rnd());
    // Pointers: X, Y loaded, then used indirectly and through direct address 80h
    emit(8'h0d); emit(a2); emit(8'h35); emit(8'h0d); emit(rnd()); emit(8'h87); emit(8'h0d); emit(rnd());
    emit(8'h47); emit(8'h0f); emit(8'h80); emit(8'h0d); emit(a1); emit(8'h75); emit(8'h17);
    emit(8'h6f); emit(a1); emit(8'hef); emit(a1); emit(8'hef); emit(a1); emit(8'h0f); emit(a1);
    emit(8'h05); emit(8'h15); emit(8'h65); emit(8'h55);
    emit(8'hbd); emit(8'hdd); emit(8'hdd); emit(8'hfd);
    // Bit set, taken test at +129, clear, taken test, not-taken test at -126, random test
    emit({b[0], b[1], b[2], 1'b1, 4'hb}); emit(a2);
    p = wp; emit({b[0], b[1], b[2], 1'b1, 4'h3}); emit(a2); emit(8'h7f); wp = p + 129;
    emit({b[0], b[1], b[2], 1'b0, 4'hb}); emit(a2);
    p = wp; emit({b[0], b[1], b[2], 1'b0, 4'h3}); emit(a2); emit(8'h02); wp = p + 4;
    emit({b[0], b[1], b[2], 1'b1, 4'h3}); emit(a2); emit(8'h80);
    emit(rnd() & 8'hf0 | 8'h03); emit(a1); emit(8'h05);
    // Forward short branches at the +16 span on random flags
    for (int t = 0; t < 4; t++)
    begin
      emit(8'h4d); emit(rnd());
      p = wp; emit({4'hf, 1'b0, 2'(t), 1'b0}); wp = p + 16;
    end
    // Backward short branches at the -14 and -15 spans, one not taken, one taken
    p = wp;
    jmp(4'h9, p + 4); jmp(4'h9, p + 18); emit(8'hed); emit(8'h00);
    wp = p + 16; emit(8'he8); emit(8'hfc);
    rom[12'h800] = 8'h1d; rom[12'h801] = 8'h3d;
    rom[12'h810] = 8'h4d; rom[12'h811] = rnd(); rom[12'h812] = 8'h5d;
    emit(8'h4d); emit(rnd()); jmp(4'h1, 12'h800); jmp(4'h1, 12'h810);
    // Immediate clear of a data byte, immediate store without effect, both read back
    emit(8'h6d); emit(a1); emit(8'h8d); emit(a2); emit(8'h0f); emit(a1); emit(8'h0f); emit(a2);
    emit(8'h7d); emit(8'h9d); emit(8'h1d);
    endAddr = wp;
    jmp(4'h9, wp);
  endtask : build

  task automatic mstep(output int cyc, output int hl, output int wt);
    logic [7:0] op, b1, b2, v;
    int         ad, r, bn, tk;
    op = rom[mPc]; b1 = rom[(mPc + 1) % 4096]; b2 = rom[(mPc + 2) % 4096];
    cyc = 4; hl = 0; wt = 0; bn = {op[5], op[6], op[7]};
    if (!op[0])
    begin
      case (op[2:1]) 2'h0: tk = !mZ; 2'h1: tk = !mC; 2'h2: tk = mZ; default: tk = mC; endcase
      cyc = 2;
      mPc = !tk ? mPc + 1 : op[3] ? mPc - op[7:4] : mPc + 1 + op[7:4];
    end
    else if (op[2:0] == 3'h1)
    begin
      if (!op[3])
      begin
        mStk.push_front(mPc + 2); svZ = mZ; svC = mC;
      end
      mPc = {op[7:4], b1};
    end
    else if (op[3:0] == 4'h3)
    begin
      cyc = 5; mC = (mMem[b1] >> bn) & 1;
      mPc = (mC == op[4]) ? mPc + 2 + int'($signed(b2)) : mPc + 3;
    end
    else if (op[3:0] == 4'hb)
    begin
      if (op[4]) mMem[b1] |= 1 << bn; else mMem[b1] &= ~(1 << bn);
      mPc += 2;
    end
    else if (op[3:0] == 4'h5)
    begin
      r = 128 + op[7:6]; mPc += 1;
      case (op[5:4]) 2'h0: mMem[r] = (mMem[r] + 1) & 255; 2'h1: mAcc = mMem[r];
        2'h2: mMem[r] = (mMem[r] + 255) & 255; default: mMem[r] = mAcc; endcase
      mZ = ((op[5:4] == 2'h1) ? mAcc : mMem[r]) == 0;
    end
    else if (op[4] && op[3:0] == 4'hd)
    begin
      mPc += 1; cyc = (op[7:5] >= 3'h5) ? 4 : 2;
      case (op[7:5])
        3'h1: mPc = mStk.pop_front();
        3'h2: begin mPc = mStk.pop_front(); mZ = svZ; mC = svC; end
        3'h3: begin hl = !mWd; wt = mWd; end
        3'h4: wt = 1;
        3'h5: begin mC = mAcc >> 7; mAcc = ~mAcc & 255; end
        3'h6: begin r = mAcc >> 7; mAcc = ((mAcc << 1) | mC) & 255; mC = r; end
        3'h7: begin mC = mAcc >> 7; mAcc = (mAcc << 1) & 255; end
        default: ;
      endcase
      if (op[7:5] >= 3'h5) mZ = mAcc == 0;
    end
    else
    begin
      ad = (op[3:0] == 4'h7) ? mMem[128 + op[4]] : b1;
      v = (op[3:0] == 4'hd) ? b1 : 8'(mMem[ad]);
      mPc += (op[3:0] == 4'h7) ? 1 : 2;
      case (op[7:5])
        3'h0: begin mAcc = v; mZ = mAcc == 0; end
        3'h1: begin mZ = mAcc == v; mC = mAcc < v; end
        3'h2: begin r = mAcc + v; mC = r > 255; mAcc = r & 255; mZ = mAcc == 0; end
        3'h3: if (op[3:0] == 4'hd) mMem[ad] = 0;
              else begin mMem[ad] = (v + 1) & 255; mZ = mMem[ad] == 0; end
        3'h4: if (op[3:0] != 4'hd) begin mMem[ad] = mAcc; mZ = mAcc == 0; end
        3'h5: begin mAcc &= v; mC = 0; mZ = mAcc == 0; end
        3'h6: begin mC = mAcc < v; mAcc = (mAcc - v) & 255; mZ = mAcc == 0; end
        default: if (op[3:0] == 4'hd) begin mAcc = 0; mZ = 1; mC = 0; end
                 else begin mMem[ad] = (v + 255) & 255; mZ = mMem[ad] == 0; end
      endcase
    end
    mPc = mPc & 12'hfff;
  endtask : mstep

  task automatic run_pass(input int wd);
    int cyc, hl, wt, n, cnt;
    @(posedge core_clk);
    arst_n <= 1'b0;
    watchdogSel <= wd[0];
    build();
    mPc = PC_RESET; mAcc = ACC_RESET; mZ = 0; mC = 0; mWd = wd; mStk.delete();
    for (int i = 0; i < WREG_COUNT; i++) mMem[WREG_BASE + i] = WREG_RESET;
    repeat (8) @(posedge core_clk);
    check("reset progAddr", progAddr, PC_RESET);
    check("reset accOut", 12'(accOut), 12'(ACC_RESET));
    check("reset flags", 12'({zeroFlag, carryFlag, instDone}), 12'h000);
    arst_n <= 1'b1;
    @(negedge core_clk);
    n = 0;
    while (mPc != endAddr && n < 400)
    begin
      cnt = 1;
      while (instDone !== 1'b1 && cnt < 20)
      begin
        @(negedge core_clk);
        cnt++;
      end
      mstep(cyc, hl, wt);
      check("cycles", 12'(cnt), 12'(cyc));
      @(negedge core_clk);
      check("progAddr", progAddr, 12'(mPc));
      check("accOut", 12'(accOut), 12'(mAcc));
      check("zeroFlag", 12'(zeroFlag), 12'(mZ));
      check("carryFlag", 12'(carryFlag), 12'(mC));
      check("haltReq", 12'(haltReq), 12'(hl));
      check("waitReq", 12'(waitReq), 12'(wt));
      n++;
    end
    check("program end", 12'(mPc), 12'(endAddr));
    $display("Program pass with watchdog option %0d ended after %0d instructions", wd, n);
  endtask : run_pass

  task automatic conclude();
    $display("Comparisons %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude

  initial
  begin
    arst_n = 1'b0;
    watchdogSel = 1'b0;
    fail_count = 0;
    checks_done = 0;
    seed = 32'ha4e76f49;
    run_pass(0);
    run_pass(1);
    conclude();
  end

  // Both passes together take well under 20 thousand cycles
  initial
  begin
    #400us;
    fail_count++;
    $display("Error run time expected completion seen timeout");
    conclude();
  end
endmodule : cie_core_tb
